//--- dbg_map.svh
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH

// ==========================================================================
// register byte offsets on the apb port
`define OFF_DCSR        8'h00
`define OFF_DPC         8'h04
`define OFF_DSCRATCH0   8'h08
`define OFF_DSCRATCH1   8'h0c
`define OFF_TSELECT     8'h10
`define OFF_TDATA1      8'h14
`define OFF_TDATA2      8'h18
`define OFF_TINFO       8'h1c
`define OFF_MSTATUS     8'h20
`define OFF_RUNSTAT     8'h24

// ==========================================================================
// debug control and status fields
`define DCSR_VER_VAL    4'h4
`define DCSR_EBREAKM    15
`define DCSR_PRV_VAL    2'h3
`define CAUSE_EBREAK    3'h1
`define CAUSE_TRIGGER   3'h2
`define CAUSE_HALTREQ   3'h3

// ==========================================================================
// machine status fields
`define MST_MIE         3
`define MST_MPIE        7

// ==========================================================================
// trigger data 1 fields and constants
`define TD1_TYPE_LSB    28
`define TD1_DMODE       27
`define TD1_ACT_LSB     12
`define TD1_EXEC        2
`define TTYPE_MCONTROL  4'h2
`define TTYPE_ETRIG     4'h5
`define ACTION_DEBUG    4'h1
`define TD1_RESET       32'h2800_0000
`define TINFO_VAL       32'h0000_0024

`endif

//--- dbg_pkg.sv
package dbg_pkg;

    // ======================================================================
    // run-control states
    typedef enum logic [1:0] {
        ST_RESET,
        ST_RUN,
        ST_HALT
    } run_state_e;

    // ======================================================================
    // apb request and response
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    // ======================================================================
    // core pipeline events, one cycle each except fetch enable, debug request and decode pc
    typedef struct packed {
        logic        fetch_enable;
        logic        debug_req;
        logic        dec_valid;
        logic [31:0] dec_pc;
        logic        ebreak;
        logic        mret;
        logic        dret;
        logic        exception;
        logic [4:0]  exc_cause;
        logic        irq_take;
    } core_evt_s;

    typedef struct packed {
        logic havereset;
        logic running;
        logic halted;
    } dbg_status_s;

    typedef struct packed {
        logic        pc_set;
        logic [31:0] pc_target;
        logic        kill_decode;
    } redirect_s;

endpackage

//--- trigger_unit.sv
`timescale 1ns/1ns
`include "dbg_map.svh"

module trigger_unit #(
    parameter int NUM_TRIG = 1
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // register access
    input  wire logic [1:0]  sel,
    input  wire logic        wr1,
    input  wire logic        wr2,
    input  wire logic [31:0] wdata,
    output      logic [31:0] rd1,
    output      logic [31:0] rd2,
    // match inputs
    input  wire logic        enable,
    input  wire logic        pc_valid,
    input  wire logic [31:0] pc,
    input  wire logic        exc,
    input  wire logic [4:0]  exc_cause,
    output      logic        hit
);
    import dbg_pkg::*;

    // one slot kept at zero triggers so arrays never go empty
    localparam int TN = (NUM_TRIG == 0) ? 1 : NUM_TRIG;

    typedef struct packed {
        logic [TN-1:0][31:0] t1;
        logic [TN-1:0][31:0] t2;
    } trig_state_s;

    trig_state_s s_r, s_nxt;
    logic [TN-1:0] hits;

    // ======================================================================
    // per-trigger match, two types only
    for (genvar i = 0; i < TN; i++) begin : g_trig
        logic [3:0] ty;
        logic [3:0] act;
        assign ty  = s_r.t1[i][`TD1_TYPE_LSB+:4];
        assign act = s_r.t1[i][`TD1_ACT_LSB+:4];
        assign hits[i] = (NUM_TRIG != 0) && enable
            && (act == `ACTION_DEBUG)
            && (((ty == `TTYPE_MCONTROL) && s_r.t1[i][`TD1_EXEC]
                 && pc_valid && (pc == s_r.t2[i]))
             || ((ty == `TTYPE_ETRIG) && exc
                 && s_r.t2[i][exc_cause]));
    end

    assign hit = |hits;
    assign rd1 = (sel < TN) ? s_r.t1[sel] : '0;
    assign rd2 = (sel < TN) ? s_r.t2[sel] : '0;

    // ======================================================================
    // writes; other types keep old type
    always_comb begin
        s_nxt = s_r;
        if (wr1 && (sel < TN)) begin
            if ((wdata[`TD1_TYPE_LSB+:4] == `TTYPE_MCONTROL) ||
                (wdata[`TD1_TYPE_LSB+:4] == `TTYPE_ETRIG)) begin
                s_nxt.t1[sel] = wdata;
            end else begin
                s_nxt.t1[sel][27:0] = wdata[27:0];
            end
            s_nxt.t1[sel][`TD1_DMODE] = 1'b1;
        end
        if (wr2 && (sel < TN)) begin
            s_nxt.t2[sel] = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.t1 <= {TN{`TD1_RESET}};
            s_r.t2 <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

//--- core_debug_entry_control.sv
// Operation
// - trap entry clears machine interrupt enable
// - no hardware trap stacking; software nests freely
// - debug entry saves pc, records cause, jumps to halt vector
// - enter debug on request, trigger with action one, or armed ebreak
// - trigger count is a parameter from zero to four
// - triggers support only address match and exception types
// - pc-dependent or program-buffer transfers never illegal
// - decode instruction at first request cycle is killed
// - has-been-reset high in reset, clears after fetch enable seen
// - exactly one of reset, running, halted status is high
// - ebreak in debug mode returns to halt vector, no status change
// - exception or mret in debug mode goes to exception vector
// - debug csr, pc and scratch registers illegal outside debug mode
// - trigger registers illegal when trigger count is zero
// - trigger mode-only bit reads one; data written only in debug
// - neither running nor halted until after fetch enable
// - request before fetch enable goes straight to halted
// - request while running reaches halted within a few cycles
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "dbg_map.svh"

module core_debug_entry_control #(
    parameter int NUM_TRIG = 1
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // register port
    input  wire dbg_pkg::apb_req_s    apb_i,
    output      dbg_pkg::apb_rsp_s    apb_o,
    // core pipeline events
    input  wire dbg_pkg::core_evt_s   core_i,
    input  wire logic [31:0]          halt_vector_in,
    input  wire logic [31:0]          debug_exception_vector_in,
    // status and redirect
    output      dbg_pkg::dbg_status_s dbg_status,
    output      dbg_pkg::redirect_s   redirect,
    output      logic                 illegal_insn,
    output      logic                 mie
);
    import dbg_pkg::*;

    typedef struct packed {
        run_state_e  st;
        logic        req_seen;
        logic        ebreakm;
        logic [2:0]  cause;
        logic [31:0] dpc;
        logic [31:0] scratch0;
        logic [31:0] scratch1;
        logic [1:0]  tsel;
        logic        mie;
        logic        mpie;
        apb_rsp_s    rsp;
        dbg_status_s stat;
        redirect_s   redir;
        logic        illegal;
    } ctl_state_s;

    ctl_state_s s_r, s_nxt;

    logic        setup;
    logic        acc_wr;
    logic        in_dbg;
    logic        bad;
    logic        t1_we;
    logic        t2_we;
    logic        trig_hit;
    logic [31:0] t1_rd;
    logic [31:0] t2_rd;
    logic [31:0] rdata;

    // ======================================================================
    // address classes
    function automatic logic is_dbg_reg(input logic [7:0] a);
        is_dbg_reg = (a == `OFF_DCSR) || (a == `OFF_DPC) ||
                     (a == `OFF_DSCRATCH0) || (a == `OFF_DSCRATCH1);
    endfunction

    function automatic logic is_trig_reg(input logic [7:0] a);
        is_trig_reg = (a == `OFF_TSELECT) || (a == `OFF_TDATA1) ||
                      (a == `OFF_TDATA2) || (a == `OFF_TINFO);
    endfunction

    function automatic logic is_known(input logic [7:0] a);
        is_known = is_dbg_reg(a) || is_trig_reg(a) ||
                   (a == `OFF_MSTATUS) || (a == `OFF_RUNSTAT);
    endfunction

    // ======================================================================
    // access checks and strobes
    assign in_dbg = (s_r.st == ST_HALT);
    assign setup  = apb_i.psel && !apb_i.penable;
    // write lands at the pready edge, never if refused
    assign acc_wr = apb_i.psel && apb_i.penable && s_r.rsp.pready &&
                    apb_i.pwrite && !s_r.rsp.pslverr;
    // no pc or target checks, only register legality
    assign bad = !is_known(apb_i.paddr)
              || (is_dbg_reg(apb_i.paddr) && !in_dbg)
              || (is_trig_reg(apb_i.paddr) && (NUM_TRIG == 0));
    // trigger data writable in debug only
    assign t1_we = acc_wr && in_dbg && (apb_i.paddr == `OFF_TDATA1);
    assign t2_we = acc_wr && in_dbg && (apb_i.paddr == `OFF_TDATA2);

    // ======================================================================
    // read multiplexer
    always_comb begin
        rdata = '0;
        case (apb_i.paddr)
            `OFF_DCSR: begin
                rdata[31:28] = `DCSR_VER_VAL;
                rdata[`DCSR_EBREAKM] = s_r.ebreakm;
                rdata[8:6] = s_r.cause;
                rdata[1:0] = `DCSR_PRV_VAL;
            end
            `OFF_DPC:       rdata = s_r.dpc;
            `OFF_DSCRATCH0: rdata = s_r.scratch0;
            `OFF_DSCRATCH1: rdata = s_r.scratch1;
            `OFF_TSELECT:   rdata[1:0] = s_r.tsel;
            `OFF_TDATA1:    rdata = t1_rd;
            `OFF_TDATA2:    rdata = t2_rd;
            `OFF_TINFO:     rdata = `TINFO_VAL;
            `OFF_MSTATUS: begin
                rdata[`MST_MIE]  = s_r.mie;
                rdata[`MST_MPIE] = s_r.mpie;
            end
            `OFF_RUNSTAT: begin
                rdata[0] = s_r.stat.havereset;
                rdata[1] = s_r.stat.running;
                rdata[2] = s_r.stat.halted;
            end
            default:        rdata = '0;
        endcase
    end

    // ======================================================================
    // trigger unit, matching only while running
    trigger_unit #(
        .NUM_TRIG (NUM_TRIG)
    ) u_trig (
        .pclk      (pclk),
        .presetn   (presetn),
        .sel       (s_r.tsel),
        .wr1       (t1_we),
        .wr2       (t2_we),
        .wdata     (apb_i.pwdata),
        .rd1       (t1_rd),
        .rd2       (t2_rd),
        .enable    (s_r.st == ST_RUN),
        .pc_valid  (core_i.dec_valid),
        .pc        (core_i.dec_pc),
        .exc       (core_i.exception),
        .exc_cause (core_i.exc_cause),
        .hit       (trig_hit)
    );

    // ======================================================================
    // next state: register port first, run control after so it wins
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.pready = 1'b0;
        s_nxt.redir.pc_set = 1'b0;
        s_nxt.redir.kill_decode = 1'b0;
        s_nxt.illegal = 1'b0;

        // answer is prepared at setup, shown in the access cycle
        if (setup) begin
            s_nxt.rsp.pready  = 1'b1;
            s_nxt.rsp.pslverr = bad;
            s_nxt.rsp.prdata  = bad ? '0 : rdata;
            s_nxt.illegal     = bad;
        end

        if (acc_wr) begin
            case (apb_i.paddr)
                `OFF_DCSR:      s_nxt.ebreakm = apb_i.pwdata[`DCSR_EBREAKM];
                `OFF_DPC:       s_nxt.dpc = apb_i.pwdata;
                `OFF_DSCRATCH0: s_nxt.scratch0 = apb_i.pwdata;
                `OFF_DSCRATCH1: s_nxt.scratch1 = apb_i.pwdata;
                `OFF_TSELECT: begin
                    // out-of-range select dropped
                    if (apb_i.pwdata < NUM_TRIG) begin
                        s_nxt.tsel = apb_i.pwdata[1:0];
                    end
                end
                `OFF_MSTATUS: begin
                    // software re-enable allows nesting
                    s_nxt.mie  = apb_i.pwdata[`MST_MIE];
                    s_nxt.mpie = apb_i.pwdata[`MST_MPIE];
                end
                default: begin
                end
            endcase
        end

        case (s_r.st)
            ST_RESET: begin
                // early request forces direct halt
                if (core_i.debug_req) begin
                    s_nxt.req_seen = 1'b1;
                end
                if (core_i.fetch_enable) begin
                    if (s_r.req_seen || core_i.debug_req) begin
                        s_nxt.st = ST_HALT;
                        s_nxt.cause = `CAUSE_HALTREQ;
                        s_nxt.dpc = core_i.dec_pc;
                        s_nxt.redir.pc_set = 1'b1;
                        s_nxt.redir.pc_target = halt_vector_in;
                        s_nxt.redir.kill_decode = 1'b1;
                    end else begin
                        s_nxt.st = ST_RUN;
                    end
                    s_nxt.req_seen = 1'b0;
                end
            end
            ST_RUN: begin
                if (trig_hit || core_i.debug_req ||
                    (core_i.ebreak && s_r.ebreakm)) begin
                    s_nxt.st = ST_HALT;
                    if (trig_hit) begin
                        s_nxt.cause = `CAUSE_TRIGGER;
                    end else if (core_i.ebreak && s_r.ebreakm) begin
                        s_nxt.cause = `CAUSE_EBREAK;
                    end else begin
                        s_nxt.cause = `CAUSE_HALTREQ;
                    end
                    s_nxt.dpc = core_i.dec_pc;
                    s_nxt.redir.pc_set = 1'b1;
                    s_nxt.redir.pc_target = halt_vector_in;
                    // decode instruction is flushed and resumes from dpc
                    s_nxt.redir.kill_decode = 1'b1;
                end else if (core_i.exception || core_i.irq_take ||
                             core_i.ebreak) begin
                    // single level of save only; handler must store it
                    s_nxt.mpie = s_r.mie;
                    s_nxt.mie  = 1'b0;
                end else if (core_i.mret) begin
                    s_nxt.mie  = s_r.mpie;
                    s_nxt.mpie = 1'b1;
                end
            end
            ST_HALT: begin
                // none of these touch dcsr, dpc or machine status
                if (core_i.ebreak) begin
                    s_nxt.redir.pc_set = 1'b1;
                    s_nxt.redir.pc_target = halt_vector_in;
                end else if (core_i.exception || core_i.mret) begin
                    s_nxt.redir.pc_set = 1'b1;
                    s_nxt.redir.pc_target = debug_exception_vector_in;
                end else if (core_i.dret) begin
                    s_nxt.st = ST_RUN;
                    s_nxt.redir.pc_set = 1'b1;
                    s_nxt.redir.pc_target = s_r.dpc;
                end
            end
            default: begin
                s_nxt.st = ST_RESET;
            end
        endcase

        // status from next state, registered
        s_nxt.stat.havereset = (s_nxt.st == ST_RESET);
        s_nxt.stat.running   = (s_nxt.st == ST_RUN);
        s_nxt.stat.halted    = (s_nxt.st == ST_HALT);
    end

    // ======================================================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.st       <= ST_RESET;
            s_r.req_seen <= 1'b0;
            s_r.ebreakm  <= 1'b0;
            s_r.cause    <= 3'h0;
            s_r.dpc      <= '0;
            s_r.scratch0 <= '0;
            s_r.scratch1 <= '0;
            s_r.tsel     <= 2'h0;
            s_r.mie      <= 1'b0;
            s_r.mpie     <= 1'b0;
            s_r.rsp      <= '0;
            s_r.stat     <= 3'b100;
            s_r.redir    <= '0;
            s_r.illegal  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================================
    // outputs straight from flip-flops
    assign apb_o        = s_r.rsp;
    assign dbg_status   = s_r.stat;
    assign redirect     = s_r.redir;
    assign illegal_insn = s_r.illegal;
    assign mie          = s_r.mie;

endmodule

//--- debug_host_model.sv
`timescale 1ns/1ns
module debug_host_model #(
    parameter logic [31:0] HALT_VEC = 32'h0000_0800,
    parameter logic [31:0] EXC_VEC  = 32'h0000_0900
) (
    // clock
    input  wire logic        pclk,
    // run-control request and vectors
    output      logic        debug_req,
    output      logic [31:0] halt_vector_in,
    output      logic [31:0] debug_exception_vector_in
);
    // ======================================================================
    // vectors, low two bits forced clear
    assign halt_vector_in            = {HALT_VEC[31:2], 2'b00};
    assign debug_exception_vector_in = {EXC_VEC[31:2], 2'b00};

    initial debug_req = 1'b0;

    // raised after an edge, held n whole cycles
    task automatic request(input int n);
        @(posedge pclk);
        debug_req <= 1'b1;
        repeat (n) @(posedge pclk);
        debug_req <= 1'b0;
    endtask
endmodule

//--- core_debug_entry_control_props.sv
`timescale 1ns/1ns
module core_debug_entry_control_props #(
    parameter int NUM_TRIG = 1
) (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // register port
    input wire dbg_pkg::apb_req_s    apb_i,
    input wire dbg_pkg::apb_rsp_s    apb_o,
    // core side
    input wire dbg_pkg::core_evt_s   core_i,
    input wire logic [31:0]          halt_vector_in,
    input wire logic [31:0]          debug_exception_vector_in,
    // status and redirect
    input wire dbg_pkg::dbg_status_s dbg_status,
    input wire dbg_pkg::redirect_s   redirect,
    input wire logic                 illegal_insn,
    input wire logic                 mie
);
    import dbg_pkg::*;

    // ======================================================================
    // run-control and register port checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_status_onehot: assert property ($onehot(dbg_status))
        else $error("status not one-hot");
    a_reset_hold: assert property (
        dbg_status.havereset && !core_i.fetch_enable |=> dbg_status.havereset)
        else $error("left reset state without fetch enable");
    a_fetch_leave: assert property (
        dbg_status.havereset && core_i.fetch_enable |=> !dbg_status.havereset)
        else $error("reset state kept after fetch enable");
    a_early_halt: assert property (
        dbg_status.havereset && core_i.fetch_enable && core_i.debug_req
        |=> dbg_status.halted)
        else $error("early request not halted");
    a_entry_redirect: assert property (
        dbg_status.running && core_i.debug_req |=> dbg_status.halted
        && redirect.pc_set && redirect.kill_decode
        && redirect.pc_target == $past(halt_vector_in))
        else $error("debug entry redirect wrong");
    a_halt_ebreak: assert property (
        dbg_status.halted && core_i.ebreak && !core_i.exception
        && !core_i.mret && !core_i.dret |=> dbg_status.halted
        && redirect.pc_set && redirect.pc_target == $past(halt_vector_in))
        else $error("debug ebreak went astray");
    a_halt_except: assert property (
        dbg_status.halted && (core_i.exception || core_i.mret)
        && !core_i.ebreak && !core_i.dret |=> dbg_status.halted
        && redirect.pc_set
        && redirect.pc_target == $past(debug_exception_vector_in))
        else $error("debug mode exception target wrong");
    a_halt_stays: assert property (
        dbg_status.halted && !core_i.dret |=> $stable(dbg_status))
        else $error("left debug mode without dret");
    a_trap_mie: assert property (
        dbg_status.running && (core_i.exception || core_i.irq_take)
        |=> !mie || dbg_status.halted)
        else $error("trap entry kept interrupt enable");
    a_apb_answer: assert property (
        apb_i.psel && !apb_i.penable |=> apb_o.pready ##1 !apb_o.pready)
        else $error("apb answer not one access cycle");
    a_refuse_zero: assert property (
        illegal_insn |-> apb_o.pslverr && apb_o.prdata == 32'h0)
        else $error("refusal not flagged");

    // main scenarios reached
    c_run_entry: cover property (dbg_status.running && core_i.debug_req);
    c_halt_ebreak: cover property (dbg_status.halted && core_i.ebreak);
    c_early: cover property (dbg_status.havereset && core_i.debug_req);
endmodule

bind core_debug_entry_control core_debug_entry_control_props #(
    .NUM_TRIG(NUM_TRIG)
) i_props (
    .pclk(pclk), .presetn(presetn), .apb_i(apb_i), .apb_o(apb_o),
    .core_i(core_i), .halt_vector_in(halt_vector_in),
    .debug_exception_vector_in(debug_exception_vector_in),
    .dbg_status(dbg_status), .redirect(redirect),
    .illegal_insn(illegal_insn), .mie(mie)
);

//--- core_debug_entry_control_tb_top.sv
`timescale 1ns/1ns
module core_debug_entry_control_tb_top;
    import dbg_pkg::*;
    localparam logic [31:0] HALT_VEC = 32'h0000_0800;
    localparam logic [31:0] EXC_VEC  = 32'h0000_0900;
    logic        pclk, presetn, debug_req, illegal, mie;
    apb_req_s    req;
    apb_rsp_s    rsp;
    core_evt_s   base, evt, core_in, e;
    logic [31:0] halt_vec, exc_vec, pc_a, tpc, data;
    dbg_status_s status;
    redirect_s   redir;
    int          n_fail, tests_run, seed;

    // request from host model, rest from bench
    always_comb begin
        core_in = evt;
        core_in.debug_req = debug_req;
    end

    core_debug_entry_control #(.NUM_TRIG(1)) i_dut (
        .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp),
        .core_i(core_in), .halt_vector_in(halt_vec),
        .debug_exception_vector_in(exc_vec), .dbg_status(status),
        .redirect(redir), .illegal_insn(illegal), .mie(mie));
    debug_host_model #(.HALT_VEC(HALT_VEC), .EXC_VEC(EXC_VEC)) i_host (
        .pclk(pclk), .debug_req(debug_req), .halt_vector_in(halt_vec),
        .debug_exception_vector_in(exc_vec));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ======================================================================
    // comparison and verdict
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // apb master, holds request until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [33:0] res);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        res = {illegal, rsp.pslverr, rsp.prdata};
        req <= '0;
        if (n >= 20) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [33:0] r;
        apb(1'b1, a, d, r);
        @(negedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                          input logic err);
        logic [33:0] r;
        apb(1'b0, a, 32'h0, r);
        check(64'(r), 64'({err, err, x}));
    endtask

    // ======================================================================
    // one-cycle event pulses over steady inputs
    function automatic core_evt_s ev(input logic [4:0] k);
        core_evt_s v;
        v = base;
        {v.irq_take, v.exception, v.dret, v.mret, v.ebreak} = k;
        return v;
    endfunction
    function automatic logic [31:0] exp_dcsr(input logic [2:0] c,
                                             input logic ebm);
        return {4'h4, 12'h0, ebm, 6'h0, c, 4'h0, 2'h3};
    endfunction
    task automatic pulse(input core_evt_s v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= base;
        @(negedge pclk);
    endtask
    task automatic chk_pc(input logic [2:0] st, input logic [31:0] t);
        check(64'({status, redir.pc_set, redir.pc_target}),
              64'({st, 1'b1, t}));
    endtask
    // entry judged at the falling edge just after the request is first sampled
    task automatic halt_req(input int n);
        fork
            i_host.request(n);
            begin
                repeat (2) @(posedge pclk);
                @(negedge pclk);
                chk_pc(3'b001, HALT_VEC);
                check(64'(redir.kill_decode), 64'h1);
            end
        join
    endtask

    // ======================================================================
    // main sequence
    initial begin
        seed = 77961;
        n_fail = 0;
        tests_run = 0;
        presetn = 1'b0;
        req = '0;
        base = '0;
        evt = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(64'(status), 64'h4);
        rd_chk(8'h24, 32'h1, 1'b0);
        rd_chk(8'h00, 32'h0, 1'b1);
        rd_chk(8'h30, 32'h0, 1'b1);
        wr(8'h14, 32'h2000_1004);
        base.fetch_enable = 1'b1;
        pulse(base);
        check(64'(status), 64'h2);
        for (int k = 3; k < 5; k++) begin
            wr(8'h20, 32'h0000_0008);
            pulse(ev(5'(1 << k)));
            check(64'(mie), 64'h0);
            rd_chk(8'h20, 32'h0000_0080, 1'b0);
            pulse(ev(5'h02));
            check(64'(mie), 64'h1);
        end
        for (int i = 1; i < 4; i++) begin
            pc_a = $random(seed);
            base.dec_pc = pc_a;
            pulse(base);
            halt_req(i);
            rd_chk(8'h04, pc_a, 1'b0);
            rd_chk(8'h00, exp_dcsr(3'h3, 1'b0), 1'b0);
            data = $random(seed);
            wr(8'h08 + 8'(4 * (i % 2)), data);
            rd_chk(8'h08 + 8'(4 * (i % 2)), data, 1'b0);
            pulse(ev(5'h01));
            chk_pc(3'b001, HALT_VEC);
            pulse(ev(5'h08));
            chk_pc(3'b001, EXC_VEC);
            pulse(ev(5'h02));
            chk_pc(3'b001, EXC_VEC);
            rd_chk(8'h00, exp_dcsr(3'h3, 1'b0), 1'b0);
            pulse(ev(5'h04));
            chk_pc(3'b010, pc_a);
        end
        halt_req(1);
        rd_chk(8'h14, 32'h2800_0000, 1'b0);
        rd_chk(8'h1c, 32'h0000_0024, 1'b0);
        tpc = $random(seed) & 32'hffff_fffc;
        wr(8'h10, 32'h0);
        wr(8'h18, tpc);
        wr(8'h14, 32'h2000_1004);
        rd_chk(8'h14, 32'h2800_1004, 1'b0);
        pulse(ev(5'h04));
        e = base;
        e.dec_valid = 1'b1;
        e.dec_pc = tpc;
        pulse(e);
        check(64'(status), 64'h1);
        rd_chk(8'h00, exp_dcsr(3'h2, 1'b0), 1'b0);
        wr(8'h00, 32'h0000_8000);
        wr(8'h14, 32'h5000_1000);
        wr(8'h18, 32'h0000_0004);
        pulse(ev(5'h04));
        pulse(ev(5'h01));
        check(64'(status), 64'h1);
        rd_chk(8'h00, exp_dcsr(3'h1, 1'b1), 1'b0);
        pulse(ev(5'h04));
        e = ev(5'h08);
        e.exc_cause = 5'd2;
        pulse(e);
        check(64'(status), 64'h1);
        // second reset: early request skips running
        @(posedge pclk);
        presetn <= 1'b0;
        base.fetch_enable = 1'b0;
        evt <= base;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        fork
            i_host.request(4);
            begin
                repeat (2) @(posedge pclk);
                base.fetch_enable = 1'b1;
                evt <= base;
                repeat (2) @(posedge pclk);
                @(negedge pclk);
                check(64'(status), 64'h1);
            end
        join
        conclude();
    end
endmodule
